// [bench/dtf_ctrl_model.sv]
`timescale 1ns/10ps
`include "dtf_params.svh"
module dtf_ctrl_model (
  input wire logic ref_clk_in,
  output logic mpc_out,
  output logic [`DTF_OP_W-1:0] op_out,
  output logic cas2_out,
  output logic array_read_out,
  output logic [`DTF_DATA_W-1:0] wr_data_out
);
  initial begin
    mpc_out = 1'b0;
    op_out = 7'h00;
    cas2_out = 1'b0;
    array_read_out = 1'b0;
    wr_data_out = 16'h0000;
  end
  // command then follow-on column, data at latency, then idle gap
  task automatic issue(input logic [6:0] op, input logic [15:0] d, input int lat);
    mpc_out <= 1'b1;
    op_out <= op;
    @(posedge ref_clk_in);
    mpc_out <= 1'b0;
    op_out <= 7'h00;
    cas2_out <= 1'b1;
    @(posedge ref_clk_in);
    cas2_out <= 1'b0;
    // latency runs from the edge after the column command edge
    repeat (lat) @(posedge ref_clk_in);
    wr_data_out <= d;
    @(posedge ref_clk_in);
    wr_data_out <= ~d;
    repeat (5) @(posedge ref_clk_in);
  endtask
  task automatic mpc_only(input logic [6:0] op);
    mpc_out <= 1'b1;
    op_out <= op;
    @(posedge ref_clk_in);
    mpc_out <= 1'b0;
    op_out <= 7'h00;
  endtask
  task automatic array_rd();
    array_read_out <= 1'b1;
    @(posedge ref_clk_in);
    array_read_out <= 1'b0;
  endtask
endmodule

// [bench/dtf_top_assertions.sv]
`timescale 1ns/10ps
`include "dtf_params.svh"
module dtf_top_assertions (
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic pd_entry_in,
  input wire logic srpd_entry_in,
  input wire logic mpc_in,
  input wire logic [`DTF_OP_W-1:0] mpc_op_in,
  input wire logic cas2_in,
  input wire logic array_read_in,
  input wire logic rd_data_valid_out,
  input wire logic dmi_oe_out,
  input wire logic [`DTF_PTR_W-1:0] wr_ptr_out,
  input wire logic [`DTF_PTR_W-1:0] rd_ptr_out,
  input wire logic osc_running_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);
  function automatic logic [2:0] nx(input logic [2:0] p);
    return (p == `DTF_LAST_PTR) ? 3'h0 : p + 3'h1;
  endfunction
  chk_reset_ptrs: assert property (disable iff (1'b0)
    !rstn_in |=> wr_ptr_out == 3'h0 && rd_ptr_out == 3'h0) else $error("reset left pointers");
  chk_pd_clear: assert property ((pd_entry_in || srpd_entry_in) |=>
    wr_ptr_out == 3'h0 && rd_ptr_out == 3'h0) else $error("entry left pointers");
  chk_wr_adv: assert property (mpc_in && mpc_op_in == `DTF_OP_WR_FIFO ##1 cas2_in |=>
    wr_ptr_out == nx($past(wr_ptr_out)) && $stable(rd_ptr_out)) else $error("write pointer");
  chk_rd_adv: assert property (mpc_in && mpc_op_in == `DTF_OP_RD_FIFO ##1 cas2_in |=>
    rd_ptr_out == nx($past(rd_ptr_out)) && $stable(wr_ptr_out)) else $error("read pointer");
  chk_array_read: assert property (array_read_in |=>
    wr_ptr_out == nx($past(wr_ptr_out)) && rd_ptr_out == nx($past(rd_ptr_out)))
    else $error("array read pointers");
  chk_nop_op: assert property (mpc_in && !mpc_op_in[6] ##1 cas2_in |=>
    $stable(wr_ptr_out) && $stable(rd_ptr_out)) else $error("nop moved pointers");
  chk_osc_start: assert property (mpc_in && mpc_op_in == `DTF_OP_OSC_START |->
    ##[1:2] osc_running_out) else $error("oscillator not started");
  chk_dmi_valid: assert property (dmi_oe_out |-> rd_data_valid_out)
    else $error("mask lane outside burst");
  chk_ptr_range: assert property (wr_ptr_out <= `DTF_LAST_PTR && rd_ptr_out <= `DTF_LAST_PTR)
    else $error("pointer out of range");
endmodule
bind dtf_top dtf_top_assertions i_chk (.ref_clk_in, .rstn_in, .pd_entry_in, .srpd_entry_in,
  .mpc_in, .mpc_op_in, .cas2_in, .array_read_in, .rd_data_valid_out, .dmi_oe_out,
  .wr_ptr_out, .rd_ptr_out, .osc_running_out);

// [bench/dtf_top_test.sv]
`timescale 1ns/10ps
`include "dtf_params.svh"
module dtf_top_test;
  logic ref_clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic pd_entry_in = 1'b0, srpd_entry_in = 1'b0, osc_tick_in = 1'b0;
  logic reg_wr_in = 1'b0, reg_rd_in = 1'b0, exp_dmi = 1'b0;
  logic [5:0] reg_addr_in = 6'h00;
  logic [7:0] reg_wdata_in = 8'h00, wl = 8'h04, rl = 8'h06, lfsr = 8'h4E, reg_rdata_out;
  logic [6:0] mpc_op_in;
  logic mpc_in, cas2_in, array_read_in, rd_data_valid_out, dmi_oe_out, osc_running_out;
  logic [15:0] wr_data_in, rd_data_out;
  logic [2:0] wr_ptr_out, rd_ptr_out;
  logic [7:0] cfg [4] = '{8'h20, 8'h20, 8'h00, 8'h20};
  logic [7:0] inv [4] = '{8'h80, 8'h40, 8'h00, 8'h00};
  int errors = 0, n_checks = 0, wp = 0, rp = 0, cyc = 0;
  int mem [5] = '{default: -1};
  int exp_q [$];
  int at_q [$];
  always #2.5 ref_clk_in = ~ref_clk_in;
  always @(negedge ref_clk_in) cyc++;
  dtf_ctrl_model i_ctrl (.ref_clk_in, .mpc_out(mpc_in), .op_out(mpc_op_in), .cas2_out(cas2_in),
    .array_read_out(array_read_in), .wr_data_out(wr_data_in));
  dtf_top i_dut (.ref_clk_in, .rstn_in, .pd_entry_in, .srpd_entry_in, .mpc_in, .mpc_op_in,
    .cas2_in, .array_read_in, .write_latency_in(wl), .read_latency_in(rl), .wr_data_in,
    .osc_tick_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out,
    .rd_data_out, .rd_data_valid_out, .dmi_oe_out, .wr_ptr_out, .rd_ptr_out, .osc_running_out);
  // ----------------------------
  // helpers
  // ----------------------------
  function automatic logic [7:0] step(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_ptrs();
    check(16'(wr_ptr_out), 16'(wp));
    check(16'(rd_ptr_out), 16'(rp));
  endtask
  task automatic reg_wr(input logic [5:0] a, input logic [7:0] d);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge ref_clk_in);
    reg_wr_in <= 1'b0;
    @(posedge ref_clk_in);
  endtask
  task automatic reg_chk(input logic [5:0] a, input logic [7:0] e);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge ref_clk_in);
    reg_rd_in <= 1'b0;
    @(posedge ref_clk_in);
    check({8'h00, reg_rdata_out}, {8'h00, e});
  endtask
  task automatic fifo_wr();
    logic [15:0] d;
    lfsr = step(lfsr);
    d = {lfsr, step(lfsr)};
    i_ctrl.issue(`DTF_OP_WR_FIFO, d, int'(wl));
    mem[wp] = int'(d);
    wp = (wp + 1) % `DTF_DEPTH;
    chk_ptrs();
  endtask
  task automatic fifo_rd();
    exp_q.push_back(mem[rp]);
    at_q.push_back(cyc + int'(rl) + 4);
    rp = (rp + 1) % `DTF_DEPTH;
    i_ctrl.issue(`DTF_OP_RD_FIFO, 16'h0000, int'(rl));
    chk_ptrs();
  endtask
  task automatic clr(input bit sr);
    if (sr) srpd_entry_in <= 1'b1;
    else pd_entry_in <= 1'b1;
    @(posedge ref_clk_in);
    srpd_entry_in <= 1'b0;
    pd_entry_in <= 1'b0;
    wp = 0;
    rp = 0;
    mem = '{default: -1};
    @(posedge ref_clk_in);
    chk_ptrs();
  endtask
  task automatic conclude();
    if (errors == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge ref_clk_in) begin
    if (rd_data_valid_out === 1'b1) begin
      if (exp_q.size() == 0) check(16'h0001, 16'h0000);
      else begin
        if (exp_q[0] >= 0) check(rd_data_out, 16'(exp_q[0]));
        check(16'(cyc), 16'(at_q[0]));
        check({15'h0, dmi_oe_out}, {15'h0, exp_dmi});
        void'(exp_q.pop_front());
        void'(at_q.pop_front());
      end
    end
  end
  initial begin
    repeat (20000) @(posedge ref_clk_in);
    errors++;
    conclude();
  end
  // ----------------------------
  // scenarios
  // ----------------------------
  initial begin
    repeat (4) @(posedge ref_clk_in);
    rstn_in <= 1'b1;
    @(posedge ref_clk_in);
    chk_ptrs();
    reg_chk(6'h12, 8'h00);
    reg_chk(6'h3F, 8'h00);
    reg_wr(6'h0D, 8'h20);
    reg_wr(6'h03, 8'h00);
    repeat (6) fifo_wr();
    repeat (6) fifo_rd();
    i_ctrl.array_rd();
    wp = (wp + 1) % `DTF_DEPTH;
    rp = (rp + 1) % `DTF_DEPTH;
    repeat (2) @(posedge ref_clk_in);
    chk_ptrs();
    i_ctrl.issue(7'h07, 16'h0000, 4);
    chk_ptrs();
    clr(1'b0);
    repeat (8) @(posedge ref_clk_in);
    repeat (3) fifo_wr();
    repeat (5) fifo_rd();
    clr(1'b1);
    for (int i = 0; i < 4; i++) begin
      reg_wr(6'h0D, cfg[i]);
      reg_wr(6'h03, inv[i]);
      exp_dmi = !cfg[i][5] || inv[i][7] || inv[i][6];
      fifo_rd();
    end
    reg_wr(6'h17, `DTF_RUNTIME_MANUAL);
    i_ctrl.mpc_only(`DTF_OP_OSC_START);
    for (int i = 0; i < 5 && osc_running_out !== 1'b1; i++) @(posedge ref_clk_in);
    lfsr = step(lfsr);
    repeat (int'(lfsr[3:0]) + 3) begin
      osc_tick_in <= 1'b1;
      @(posedge ref_clk_in);
    end
    osc_tick_in <= 1'b0;
    i_ctrl.mpc_only(`DTF_OP_OSC_STOP);
    repeat (3) @(posedge ref_clk_in);
    check({15'h0, osc_running_out}, 16'h0000);
    reg_chk(6'h12, {4'h0, lfsr[3:0]} + 8'h03);
    reg_chk(6'h13, 8'h00);
    reg_wr(6'h17, 8'h01);
    i_ctrl.mpc_only(`DTF_OP_OSC_START);
    repeat (2) @(posedge ref_clk_in);
    osc_tick_in <= 1'b1;
    repeat (5) @(posedge ref_clk_in);
    osc_tick_in <= 1'b0;
    i_ctrl.mpc_only(`DTF_OP_OSC_STOP);
    @(posedge ref_clk_in);
    check({15'h0, osc_running_out}, 16'h0001);
    repeat (20) @(posedge ref_clk_in);
    check({15'h0, osc_running_out}, 16'h0000);
    reg_chk(6'h12, 8'h05);
    check(16'(exp_q.size()), 16'h0000);
    conclude();
  end
endmodule

// [shared/dtf_params.svh]
`ifndef DTF_PARAMS_SVH
`define DTF_PARAMS_SVH
// fifo geometry
`define DTF_DEPTH 5
`define DTF_PTR_W 3
`define DTF_LAST_PTR 3'h4
`define DTF_DATA_W 16
// mode register offsets and field positions
`define DTF_ADDR_INV 6'h03
`define DTF_ADDR_CTRL 6'h0D
`define DTF_ADDR_CNT_LO 6'h12
`define DTF_ADDR_CNT_HI 6'h13
`define DTF_ADDR_RUNTIME 6'h17
`define DTF_DM_DISABLE_BIT 5
`define DTF_WDBI_BIT 7
`define DTF_RDBI_BIT 6
// multi-purpose command operand decode
`define DTF_OP_W 7
`define DTF_OP_ENABLE_BIT 6
`define DTF_OP_WR_FIFO 7'h47
`define DTF_OP_RD_FIFO 7'h41
`define DTF_OP_OSC_START 7'h4B
`define DTF_OP_OSC_STOP 7'h4D
// oscillator
`define DTF_CNT_W 16
`define DTF_CNT_MAX 16'hFFFF
`define DTF_RUNTIME_W 8
`define DTF_RUNTIME_MANUAL 8'h00
`define DTF_RUNTIME_SCALE 16
`endif

// [shared/dtf_pkg.sv]
package dtf_pkg;
  typedef enum logic [1:0] {
    DTF_MPC_NONE,
    DTF_MPC_WR_FIFO,
    DTF_MPC_RD_FIFO,
    DTF_MPC_OTHER
  } dtf_mpc_t;
  typedef enum logic [1:0] {
    DTF_OSC_IDLE,
    DTF_OSC_RUN,
    DTF_OSC_DONE
  } dtf_osc_state_t;
endpackage

// [src/dtf_mem.sv]
`timescale 1ns/10ps
`include "dtf_params.svh"
module dtf_mem (
  input wire logic ref_clk_in,
  input wire logic wr_en_in,
  input wire logic [`DTF_PTR_W-1:0] wr_addr_in,
  input wire logic [`DTF_DATA_W-1:0] wr_data_in,
  input wire logic rd_en_in,
  input wire logic [`DTF_PTR_W-1:0] rd_addr_in,
  output logic [`DTF_DATA_W-1:0] rd_data_out
);
  // entries are left unreset: unwritten words read back undefined but valid
  logic [`DTF_DATA_W-1:0] mem [0:`DTF_DEPTH-1];
  always_ff @(posedge ref_clk_in) begin
    if (wr_en_in) begin
      mem[wr_addr_in] <= wr_data_in;
    end
  end
  always_ff @(posedge ref_clk_in) begin
    if (rd_en_in) begin
      rd_data_out <= mem[rd_addr_in];
    end
  end
endmodule

// [src/dtf_osc.sv]
`timescale 1ns/10ps
`include "dtf_params.svh"
module dtf_osc (
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic start_in,
  input wire logic stop_in,
  input wire logic tick_in,
  input wire logic [`DTF_RUNTIME_W-1:0] runtime_in,
  output logic running_out,
  output logic done_out,
  output logic [`DTF_CNT_W-1:0] count_out
);
  dtf_pkg::dtf_osc_state_t state;
  logic [`DTF_CNT_W-1:0] count;
  logic [`DTF_CNT_W+`DTF_RUNTIME_W-1:0] clocks;
  logic [`DTF_CNT_W+`DTF_RUNTIME_W-1:0] limit;
  logic auto_stop;
  logic stop_now;
  assign limit = (`DTF_CNT_W+`DTF_RUNTIME_W)'(runtime_in) * (`DTF_CNT_W+`DTF_RUNTIME_W)'(`DTF_RUNTIME_SCALE);
  assign auto_stop = (runtime_in != `DTF_RUNTIME_MANUAL) && (clocks + 1'b1 >= limit);
  // stop command ignored when automatic stop selected
  assign stop_now = (state == dtf_pkg::DTF_OSC_RUN) &&
                    (auto_stop || (stop_in && runtime_in == `DTF_RUNTIME_MANUAL));
  assign running_out = (state == dtf_pkg::DTF_OSC_RUN);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      state <= dtf_pkg::DTF_OSC_IDLE;
    end else begin
      unique case (state)
        dtf_pkg::DTF_OSC_IDLE, dtf_pkg::DTF_OSC_DONE: begin
          if (start_in) begin
            state <= dtf_pkg::DTF_OSC_RUN;
          end else begin
            state <= dtf_pkg::DTF_OSC_IDLE;
          end
        end
        dtf_pkg::DTF_OSC_RUN: begin
          if (stop_now) begin
            state <= dtf_pkg::DTF_OSC_DONE;
          end
        end
        default: state <= dtf_pkg::DTF_OSC_IDLE;
      endcase
    end
  end
  // ------------------------------------------------------------
  // counters
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      count <= 16'h0000;
      clocks <= '0;
    end else if (start_in && state != dtf_pkg::DTF_OSC_RUN) begin
      count <= 16'h0000;
      clocks <= '0;
    end else if (state == dtf_pkg::DTF_OSC_RUN) begin
      clocks <= clocks + 1'b1;
      if (tick_in && count != `DTF_CNT_MAX) begin
        count <= count + 1'b1;
      end
    end
  end
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      done_out <= 1'b0;
      count_out <= 16'h0000;
    end else begin
      done_out <= stop_now;
      if (stop_now) begin
        count_out <= count;
      end
    end
  end
endmodule

// [src/dtf_top.sv]
// The placing of the registers and the plain strobed port were decided locally.
`timescale 1ns/10ps
`include "dtf_params.svh"
// Notes on behaviour
// - both pointers clear on power-up, reset, power-down and self-refresh power-down entry
// - fifo write advances write pointer; fifo read advances read pointer
// - ordinary array read advances both pointers
// - fifo write accepted regardless of bank, refresh or self-refresh state
// - fifo write uses normal write latency timing
// - fifo writes accepted one at a time; a second inside the write latency drops the first's data
// - five entries held; sixth write overwrites first; unwritten data undefined
// - fifo reads handled one at a time; a second inside the read latency drops the first's burst
// - fifo read uses normal read latency timing
// - reads non-destructive; read pointer wraps after five
// - mask/inversion lanes driven when inversion or masking enabled
// - start command starts oscillator counting clock-tree traversals
// - oscillator stops on command or after programmed run time
// - count stored in low and high count registers on stop
// - latency counted from second edge of the follow-on column command
// - counter saturates at maximum; low byte and high byte registers
// - operand bit six low means no-operation
module dtf_top (
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic pd_entry_in,
  input wire logic srpd_entry_in,
  input wire logic mpc_in,
  input wire logic [`DTF_OP_W-1:0] mpc_op_in,
  input wire logic cas2_in,
  input wire logic array_read_in,
  input wire logic [7:0] write_latency_in,
  input wire logic [7:0] read_latency_in,
  input wire logic [`DTF_DATA_W-1:0] wr_data_in,
  input wire logic osc_tick_in,
  input wire logic [5:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  output logic [`DTF_DATA_W-1:0] rd_data_out,
  output logic rd_data_valid_out,
  output logic dmi_oe_out,
  output logic [`DTF_PTR_W-1:0] wr_ptr_out,
  output logic [`DTF_PTR_W-1:0] rd_ptr_out,
  output logic osc_running_out
);
  localparam logic [5:0] ADDR_CTRL = `DTF_ADDR_CTRL;
  localparam logic [5:0] ADDR_INV = `DTF_ADDR_INV;
  localparam logic [5:0] ADDR_CNT_LO = `DTF_ADDR_CNT_LO;
  localparam logic [5:0] ADDR_CNT_HI = `DTF_ADDR_CNT_HI;
  localparam logic [5:0] ADDR_RUNTIME = `DTF_ADDR_RUNTIME;
  localparam int DM_DISABLE_BIT = `DTF_DM_DISABLE_BIT;
  localparam int WDBI_BIT = `DTF_WDBI_BIT;
  localparam int RDBI_BIT = `DTF_RDBI_BIT;

  function automatic logic [`DTF_PTR_W-1:0] ptr_inc(input logic [`DTF_PTR_W-1:0] p);
    ptr_inc = (p == `DTF_LAST_PTR) ? '0 : p + 1'b1;
  endfunction

  function automatic dtf_pkg::dtf_mpc_t mpc_decode(input logic [`DTF_OP_W-1:0] op);
    if (!op[`DTF_OP_ENABLE_BIT]) begin
      mpc_decode = dtf_pkg::DTF_MPC_NONE;
    end else if (op == `DTF_OP_WR_FIFO) begin
      mpc_decode = dtf_pkg::DTF_MPC_WR_FIFO;
    end else if (op == `DTF_OP_RD_FIFO) begin
      mpc_decode = dtf_pkg::DTF_MPC_RD_FIFO;
    end else begin
      mpc_decode = dtf_pkg::DTF_MPC_OTHER;
    end
  endfunction

  // ------------------------------------------------------------
  // mode registers
  // ------------------------------------------------------------
  logic [7:0] training_control_reg;
  logic [7:0] inversion_reg;
  logic [7:0] osc_runtime_setting;
  logic [7:0] osc_count_low_reg;
  logic [7:0] osc_count_high_reg;
  logic osc_done;
  logic [`DTF_CNT_W-1:0] osc_count;

  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      training_control_reg <= 8'h00;
      inversion_reg <= 8'h00;
      osc_runtime_setting <= 8'h00;
    end else if (reg_wr_in) begin
      unique case (reg_addr_in)
        ADDR_CTRL: training_control_reg <= reg_wdata_in;
        ADDR_INV: inversion_reg <= reg_wdata_in;
        ADDR_RUNTIME: osc_runtime_setting <= reg_wdata_in;
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      osc_count_low_reg <= 8'h00;
      osc_count_high_reg <= 8'h00;
    end else if (osc_done) begin
      osc_count_low_reg <= osc_count[7:0];
      osc_count_high_reg <= osc_count[15:8];
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      unique case (reg_addr_in)
        ADDR_CTRL: reg_rdata_out <= training_control_reg;
        ADDR_INV: reg_rdata_out <= inversion_reg;
        ADDR_RUNTIME: reg_rdata_out <= osc_runtime_setting;
        ADDR_CNT_LO: reg_rdata_out <= osc_count_low_reg;
        ADDR_CNT_HI: reg_rdata_out <= osc_count_high_reg;
        default: reg_rdata_out <= 8'h00;
      endcase
    end else begin
      reg_rdata_out <= 8'h00;
    end
  end

  // ------------------------------------------------------------
  // command decode
  // ------------------------------------------------------------
  dtf_pkg::dtf_mpc_t pending;
  dtf_pkg::dtf_mpc_t cmd;
  logic fifo_wr_cmd;
  logic fifo_rd_cmd;
  logic osc_start;
  logic osc_stop;

  assign cmd = mpc_in ? mpc_decode(mpc_op_in) : dtf_pkg::DTF_MPC_NONE;
  assign osc_start = cmd == dtf_pkg::DTF_MPC_OTHER && mpc_op_in == `DTF_OP_OSC_START;
  assign osc_stop = cmd == dtf_pkg::DTF_MPC_OTHER && mpc_op_in == `DTF_OP_OSC_STOP;

  // fifo commands take effect on the follow-on column command
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      pending <= dtf_pkg::DTF_MPC_NONE;
    end else if (cmd == dtf_pkg::DTF_MPC_WR_FIFO || cmd == dtf_pkg::DTF_MPC_RD_FIFO) begin
      pending <= cmd;
    end else if (cas2_in || mpc_in) begin
      pending <= dtf_pkg::DTF_MPC_NONE;
    end
  end

  // accepted in any bank, refresh or self-refresh state
  assign fifo_wr_cmd = cas2_in && pending == dtf_pkg::DTF_MPC_WR_FIFO;
  assign fifo_rd_cmd = cas2_in && pending == dtf_pkg::DTF_MPC_RD_FIFO;

  // ------------------------------------------------------------
  // pointers
  // ------------------------------------------------------------
  logic [`DTF_PTR_W-1:0] wr_ptr;
  logic [`DTF_PTR_W-1:0] rd_ptr;
  logic ptr_clear;
  assign ptr_clear = pd_entry_in || srpd_entry_in;

  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in || ptr_clear) begin
      wr_ptr <= '0;
    end else if (fifo_wr_cmd || array_read_in) begin
      wr_ptr <= ptr_inc(wr_ptr);
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in || ptr_clear) begin
      rd_ptr <= '0;
    end else if (fifo_rd_cmd || array_read_in) begin
      rd_ptr <= ptr_inc(rd_ptr);
    end
  end
  assign wr_ptr_out = wr_ptr;
  assign rd_ptr_out = rd_ptr;

  // ------------------------------------------------------------
  // latency timing from the column command edge
  // ------------------------------------------------------------
  logic [7:0] wl_cnt;
  logic [7:0] rl_cnt;
  logic [`DTF_PTR_W-1:0] wl_addr;
  logic [`DTF_PTR_W-1:0] rl_addr;
  logic wl_busy;
  logic rl_busy;
  logic mem_wr;
  logic mem_rd;

  // one burst in flight per direction; a second command inside the latency pipe reloads it and drops the first
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      wl_busy <= 1'b0;
      wl_cnt <= 8'h00;
      wl_addr <= '0;
    end else if (fifo_wr_cmd) begin
      wl_busy <= 1'b1;
      wl_cnt <= write_latency_in;
      wl_addr <= wr_ptr;
    end else if (wl_busy) begin
      wl_cnt <= wl_cnt - 8'h01;
      wl_busy <= wl_cnt != 8'h00;
    end
  end
  assign mem_wr = wl_busy && wl_cnt == 8'h00;

  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      rl_busy <= 1'b0;
      rl_cnt <= 8'h00;
      rl_addr <= '0;
    end else if (fifo_rd_cmd) begin
      rl_busy <= 1'b1;
      rl_cnt <= read_latency_in;
      rl_addr <= rd_ptr;
    end else if (rl_busy) begin
      rl_cnt <= rl_cnt - 8'h01;
      rl_busy <= rl_cnt != 8'h00;
    end
  end
  assign mem_rd = rl_busy && rl_cnt == 8'h00;

  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      rd_data_valid_out <= 1'b0;
      dmi_oe_out <= 1'b0;
    end else begin
      rd_data_valid_out <= mem_rd;
      dmi_oe_out <= mem_rd && (!training_control_reg[DM_DISABLE_BIT] ||
                    inversion_reg[WDBI_BIT] || inversion_reg[RDBI_BIT]);
    end
  end

  dtf_mem u_mem (
    .ref_clk_in(ref_clk_in),
    .wr_en_in(mem_wr),
    .wr_addr_in(wl_addr),
    .wr_data_in(wr_data_in),
    .rd_en_in(mem_rd),
    .rd_addr_in(rl_addr),
    .rd_data_out(rd_data_out)
  );

  dtf_osc u_osc (
    .ref_clk_in(ref_clk_in),
    .rstn_in(rstn_in),
    .start_in(osc_start),
    .stop_in(osc_stop),
    .tick_in(osc_tick_in),
    .runtime_in(osc_runtime_setting),
    .running_out(osc_running_out),
    .done_out(osc_done),
    .count_out(osc_count)
  );
endmodule
